// ### txrs_defs.svh
// timing counts, field positions and reset values of the transmit reset and ready sequencer
`ifndef TXRS_DEFS_SVH
`define TXRS_DEFS_SVH

// ------------------------------------------------------------
// clock
// ------------------------------------------------------------
`define TXRS_CLK_MHZ         200

// ------------------------------------------------------------
// times in their own units, as printed
// ------------------------------------------------------------
`define TXRS_RST_MIN_US      100
`define TXRS_SETTLE_MS       2
`define TXRS_RST_MARGIN_CYC  20'h00010

// ------------------------------------------------------------
// cycle counts: the first two derived from the times, the others given directly
// ------------------------------------------------------------
`define TXRS_RST_MIN_CYC     (`TXRS_RST_MIN_US * `TXRS_CLK_MHZ)
`define TXRS_SETTLE_CYC      (`TXRS_SETTLE_MS * 1000 * `TXRS_CLK_MHZ)
`define TXRS_START_CYC_DEF   20'h01000
`define TXRS_OFF_HOLD_DEF    20'h00800

// ------------------------------------------------------------
// status word layout
// ------------------------------------------------------------
`define TXRS_STAT_W          8
`define TXRS_STAT_READY_BIT  1
`define TXRS_STAT_RST        8'h00
`define TXRS_CNT_W           20

`endif

// ### txrs_pkg.sv
// types shared by both ends of the transmit reset and ready sequencer
package txrs_pkg;

    typedef enum logic [4:0] {
        D_RST   = 5'h01,
        D_OFF   = 5'h02,
        D_RAMP  = 5'h04,
        D_READY = 5'h08,
        D_HOLD  = 5'h10
    } txrs_dev_state_e;

    typedef enum logic [4:0] {
        H_IDLE = 5'h01,
        H_RST  = 5'h02,
        H_WAIT = 5'h04,
        H_SEND = 5'h08,
        H_OFF  = 5'h10
    } txrs_host_state_e;

    typedef enum logic [1:0] {
        M_TIME = 2'h0,
        M_POLL = 2'h1,
        M_PIN  = 2'h2
    } txrs_meth_e;

    typedef struct packed {
        txrs_dev_state_e state;
        logic [1:0]      rst_sync;
        logic [1:0]      frc_sync;
        logic [1:0]      dat_sync;
        logic [19:0]     cnt;
        logic [19:0]     low_cnt;
        logic            ready;
        logic            tx_on;
        logic            mod_data;
        logic [7:0]      stat;
    } txrs_dev_s;

    typedef struct packed {
        txrs_host_state_e state;
        logic [1:0]       rdy_sync;
        logic [1:0]       stat_sync;
        logic [19:0]      cnt;
        txrs_meth_e       meth;
        logic             auto_m;
        logic             rst_oe;
        logic             force_tx;
        logic             data;
        logic             go;
        logic             done;
    } txrs_host_s;

endpackage : txrs_pkg

// ### txrs_if.sv
// link between the transmitter and its companion host
`include "txrs_defs.svh"

interface txrs_if (
    input wire logic sys_clk_i
);
    logic                     ext_rst_low_out;
    logic                     ext_rst_low_oe;
    logic                     external_reset_low;
    logic                     ctrl_force;
    logic                     data;
    logic                     tx_ready;
    logic [`TXRS_STAT_W-1:0]  stat_word;

    // open drain with pull-up: released pin reads high
    assign external_reset_low = ext_rst_low_oe ? ext_rst_low_out : 1'b1;

    modport device (
        input  external_reset_low,
        input  ctrl_force,
        input  data,
        output tx_ready,
        output stat_word
    );

    modport host (
        output ext_rst_low_out,
        output ext_rst_low_oe,
        output ctrl_force,
        output data,
        input  tx_ready,
        input  stat_word
    );
endinterface : txrs_if

// ### txrs_device.sv
// transmitter end: filtered reset, ramp and ready sequencing
`include "txrs_defs.svh"

module txrs_device #(
    parameter logic [19:0] RST_MIN_CYC  = 20'(`TXRS_RST_MIN_CYC),
    parameter logic [19:0] RAMP_CYC     = 20'(`TXRS_START_CYC_DEF),
    parameter logic [19:0] OFF_HOLD_CYC = `TXRS_OFF_HOLD_DEF
) (
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    txrs_if.device    lnk,
    input  wire logic auto_mode_i,
    output wire logic tx_ready_o,
    output wire logic tx_on_o,
    output wire logic mod_data_o,
    output wire logic in_reset_o
);

    // limitations: auto_mode_i is read live and must only change while the
    // transmitter is off; ramp and hold lengths are parameters, since the
    // analog phases behind them are not modelled and vary with the crystal

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    txrs_pkg::txrs_dev_s r;
    txrs_pkg::txrs_dev_s nxt;

    logic pin_low;
    logic frc_s;
    logic dat_s;
    logic want_on;
    logic long_low;

    // ------------------------------------------------------------
    // decoding used in more than one place
    // ------------------------------------------------------------
    // ready also covers the hold time, while the carrier is still up
    function automatic logic dec_ready(input txrs_pkg::txrs_dev_state_e s);
        return (s == txrs_pkg::D_READY) || (s == txrs_pkg::D_HOLD);
    endfunction : dec_ready

    function automatic logic dec_on(input txrs_pkg::txrs_dev_state_e s);
        return (s == txrs_pkg::D_RAMP) || dec_ready(s);
    endfunction : dec_on

    function automatic logic cnt_last(input logic [19:0] c, input logic [19:0] lim);
        return (c == lim - 20'h00001);
    endfunction : cnt_last

    function automatic logic [19:0] cnt_step(input logic [19:0] c);
        return c + 20'h00001;
    endfunction : cnt_step

    // the glitch filter saturates here instead of wrapping
    function automatic logic low_full(input logic [19:0] c);
        return (c == RST_MIN_CYC);
    endfunction : low_full

    function automatic logic [`TXRS_STAT_W-1:0] stat_pack(input logic rdy);
        logic [`TXRS_STAT_W-1:0] w;
        w = `TXRS_STAT_RST;
        w[`TXRS_STAT_READY_BIT] = rdy;
        return w;
    endfunction : stat_pack

    // ------------------------------------------------------------
    // synchronised pin levels
    // ------------------------------------------------------------
    assign pin_low = ~r.rst_sync[1];
    assign frc_s   = r.frc_sync[1];
    assign dat_s   = r.dat_sync[1];

    // ------------------------------------------------------------
    // turn-on request and long-low detection
    // ------------------------------------------------------------
    // auto mode wakes on data activity, forced mode follows the control line
    assign want_on  = auto_mode_i ? dat_s : frc_s;
    assign long_low = pin_low && low_full(r.low_cnt);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt = r;
        nxt.rst_sync = {r.rst_sync[0], lnk.external_reset_low};
        nxt.frc_sync = {r.frc_sync[0], lnk.ctrl_force};
        nxt.dat_sync = {r.dat_sync[0], lnk.data};

        // short glitches on the reset pin are ignored; the count saturates
        if (!pin_low) begin
            nxt.low_cnt = 20'h00000;
        end else if (!low_full(r.low_cnt)) begin
            nxt.low_cnt = cnt_step(r.low_cnt);
        end

        unique case (r.state)
            txrs_pkg::D_RST: begin
                // stays here while the pin is held low at power-up
                nxt.cnt = 20'h00000;
                if (!pin_low) begin
                    nxt.state = txrs_pkg::D_OFF;
                end
            end
            txrs_pkg::D_OFF: begin
                // in auto mode the waking data edge is spent on the ramp, not sent
                nxt.cnt = 20'h00000;
                if (want_on) begin
                    nxt.state = txrs_pkg::D_RAMP;
                end
            end
            txrs_pkg::D_RAMP: begin
                // a forced request dropped mid-ramp aborts; the next one ramps from zero
                if (!auto_mode_i && !frc_s) begin
                    nxt.state = txrs_pkg::D_OFF;
                end else if (cnt_last(r.cnt, RAMP_CYC)) begin
                    nxt.state = txrs_pkg::D_READY;
                    nxt.cnt   = 20'h00000;
                end else begin
                    nxt.cnt = cnt_step(r.cnt);
                end
            end
            txrs_pkg::D_READY: begin
                if (auto_mode_i) begin
                    if (!dat_s) begin
                        nxt.state = txrs_pkg::D_HOLD;
                        nxt.cnt   = 20'h00000;
                    end
                end else if (!frc_s) begin
                    // forced mode turns off at once, no hold time
                    nxt.state = txrs_pkg::D_OFF;
                end
            end
            txrs_pkg::D_HOLD: begin
                // automatic turn-off only after data stays idle for the hold time
                if (dat_s) begin
                    nxt.state = txrs_pkg::D_READY;
                    nxt.cnt   = 20'h00000;
                end else if (cnt_last(r.cnt, OFF_HOLD_CYC)) begin
                    nxt.state = txrs_pkg::D_OFF;
                    nxt.cnt   = 20'h00000;
                end else begin
                    nxt.cnt = cnt_step(r.cnt);
                end
            end
            default: begin
                nxt.state = txrs_pkg::D_RST;
                nxt.cnt   = 20'h00000;
            end
        endcase

        // a long low on the pin overrides everything: full reset
        if (long_low) begin
            nxt.state = txrs_pkg::D_RST;
            nxt.cnt   = 20'h00000;
        end

        nxt.ready    = dec_ready(nxt.state);
        nxt.tx_on    = dec_on(nxt.state);
        nxt.mod_data = nxt.ready && dat_s;

        nxt.stat = stat_pack(nxt.ready);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // each field is listed so none can escape the reset
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r.state    <= txrs_pkg::D_RST;
            r.rst_sync <= 2'h0;
            r.frc_sync <= 2'h0;
            r.dat_sync <= 2'h0;
            r.cnt      <= 20'h00000;
            r.low_cnt  <= 20'h00000;
            r.ready    <= 1'b0;
            r.tx_on    <= 1'b0;
            r.mod_data <= 1'b0;
            r.stat     <= `TXRS_STAT_RST;
        end else begin
            r <= nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign lnk.tx_ready  = r.ready;
    assign lnk.stat_word = r.stat;
    assign tx_ready_o    = r.ready;
    assign tx_on_o       = r.tx_on;
    assign mod_data_o    = r.mod_data;
    // decoded from the state register alone, so inputs cannot glitch it
    assign in_reset_o    = (r.state == txrs_pkg::D_RST);

endmodule : txrs_device

// ### txrs_host.sv
// host end: drives reset, turns the transmitter on, waits for readiness, sends and stops
`include "txrs_defs.svh"

module txrs_host #(
    parameter logic [19:0] RST_MIN_CYC  = 20'(`TXRS_RST_MIN_CYC),
    parameter logic [19:0] SETTLE_CYC   = 20'(`TXRS_SETTLE_CYC),
    parameter logic [19:0] START_CYC    = `TXRS_START_CYC_DEF,
    parameter logic [19:0] OFF_HOLD_CYC = `TXRS_OFF_HOLD_DEF
) (
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_n_i,
    txrs_if.host                      lnk,
    input  wire logic                 rst_req_i,
    input  wire logic                 start_i,
    input  wire logic                 auto_i,
    input  wire txrs_pkg::txrs_meth_e method_i,
    input  wire logic                 bit_i,
    input  wire logic                 stop_i,
    output wire logic                 busy_o,
    output wire logic                 go_o,
    output wire logic                 done_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    txrs_pkg::txrs_host_s r;
    txrs_pkg::txrs_host_s nxt;

    logic [19:0] rst_hold;
    logic [19:0] wait_cyc;
    logic        seen_ready;

    // hold margin covers the far end's two-flop synchroniser
    assign rst_hold = RST_MIN_CYC + `TXRS_RST_MARGIN_CYC;
    assign wait_cyc = r.auto_m ? START_CYC : SETTLE_CYC;

    always_comb begin
        unique case (r.meth)
            txrs_pkg::M_POLL: seen_ready = r.stat_sync[1];
            txrs_pkg::M_PIN:  seen_ready = r.rdy_sync[1];
            default:          seen_ready = (r.cnt == wait_cyc - 20'h00001);
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt = r;
        nxt.rdy_sync  = {r.rdy_sync[0], lnk.tx_ready};
        nxt.stat_sync = {r.stat_sync[0], lnk.stat_word[`TXRS_STAT_READY_BIT]};
        nxt.done = 1'b0;
        nxt.go   = 1'b0;

        unique case (r.state)
            txrs_pkg::H_IDLE: begin
                nxt.cnt = 20'h00000;
                if (rst_req_i) begin
                    nxt.state  = txrs_pkg::H_RST;
                    nxt.rst_oe = 1'b1;
                end else if (start_i) begin
                    nxt.auto_m = auto_i;
                    // polling is only meaningful in forced mode
                    nxt.meth   = (auto_i && method_i == txrs_pkg::M_POLL) ?
                                 txrs_pkg::M_TIME : method_i;
                    nxt.state  = txrs_pkg::H_WAIT;
                    if (auto_i) begin
                        nxt.data = 1'b1;
                    end else begin
                        nxt.force_tx = 1'b1;
                    end
                end
            end
            txrs_pkg::H_RST: begin
                if (r.cnt == rst_hold) begin
                    nxt.rst_oe = 1'b0;
                    nxt.state  = txrs_pkg::H_IDLE;
                    nxt.done   = 1'b1;
                end else begin
                    nxt.cnt = r.cnt + 20'h00001;
                end
            end
            txrs_pkg::H_WAIT: begin
                nxt.cnt = r.cnt + 20'h00001;
                if (seen_ready) begin
                    nxt.state = txrs_pkg::H_SEND;
                    nxt.go    = 1'b1;
                end
            end
            txrs_pkg::H_SEND: begin
                nxt.go   = 1'b1;
                nxt.data = bit_i;
                if (stop_i) begin
                    nxt.go   = 1'b0;
                    nxt.data = 1'b0;
                    nxt.cnt  = 20'h00000;
                    if (r.auto_m) begin
                        nxt.state = txrs_pkg::H_OFF;
                    end else begin
                        nxt.force_tx = 1'b0;
                        nxt.state    = txrs_pkg::H_IDLE;
                        nxt.done     = 1'b1;
                    end
                end
            end
            txrs_pkg::H_OFF: begin
                if (r.cnt == OFF_HOLD_CYC + `TXRS_RST_MARGIN_CYC) begin
                    nxt.state = txrs_pkg::H_IDLE;
                    nxt.done  = 1'b1;
                end else begin
                    nxt.cnt = r.cnt + 20'h00001;
                end
            end
            default: begin
                nxt.state = txrs_pkg::H_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r.state     <= txrs_pkg::H_IDLE;
            r.rdy_sync  <= 2'h0;
            r.stat_sync <= 2'h0;
            r.cnt       <= 20'h00000;
            r.meth      <= txrs_pkg::M_TIME;
            r.auto_m    <= 1'b0;
            r.rst_oe    <= 1'b0;
            r.force_tx  <= 1'b0;
            r.data      <= 1'b0;
            r.go        <= 1'b0;
            r.done      <= 1'b0;
        end else begin
            r <= nxt;
        end
    end

    assign lnk.ext_rst_low_out = 1'b0;
    assign lnk.ext_rst_low_oe  = r.rst_oe;
    assign lnk.ctrl_force      = r.force_tx;
    assign lnk.data            = r.data;
    assign busy_o              = (r.state != txrs_pkg::H_IDLE);
    assign go_o                = r.go;
    assign done_o              = r.done;

endmodule : txrs_host

// ### txrs_properties.sv
// concurrent checks on the link between the transmitter and its host
`include "txrs_defs.svh"

module txrs_properties #(
    parameter logic [19:0] RST_MIN_CYC = 20'h00014,
    parameter logic [19:0] RAMP_CYC    = 20'h00010
) (
    input wire logic                    sys_clk_i,
    input wire logic                    rst_n_i,
    input wire logic                    ext_rst_low_out,
    input wire logic                    ext_rst_low_oe,
    input wire logic                    external_reset_low,
    input wire logic                    ctrl_force,
    input wire logic                    data,
    input wire logic                    tx_ready,
    input wire logic [`TXRS_STAT_W-1:0] stat_word
);
    // window for the ready edge, counted after eight quiet cycles
    localparam int RDY_LO = int'(RAMP_CYC) - 4;
    localparam int RDY_HI = int'(RAMP_CYC) - 1;

    logic [19:0] low_cnt_r;
    logic [19:0] oe_cnt_r;

    // ------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------
    // both saturate so a stuck pin cannot wrap them back into range
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            low_cnt_r <= 20'h00000;
            oe_cnt_r  <= 20'h00000;
        end else begin
            low_cnt_r <= external_reset_low ? 20'h00000 : low_cnt_r + {19'h00000, ~&low_cnt_r};
            oe_cnt_r  <= !ext_rst_low_oe ? 20'h00000 : oe_cnt_r + {19'h00000, ~&oe_cnt_r};
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_flag_mirrors_pin;
        tx_ready == stat_word[`TXRS_STAT_READY_BIT];
    endproperty
    a_flag_mirrors_pin: assert property (p_flag_mirrors_pin) else $error("ready flag differs from ready pin");

    property p_stat_reserved_zero;
        stat_word[`TXRS_STAT_W-1:2] == '0 && stat_word[0] == 1'b0;
    endproperty
    a_stat_reserved_zero: assert property (p_stat_reserved_zero) else $error("status word spare bits set");

    property p_ready_after_ramp;
        $rose(ctrl_force) && !tx_ready |-> !tx_ready[*8] ##[RDY_LO:RDY_HI] tx_ready;
    endproperty
    a_ready_after_ramp: assert property (p_ready_after_ramp) else $error("ready edge off its ramp time");

    property p_ready_drops_when_off;
        $fell(ctrl_force) |-> ##[1:5] !tx_ready;
    endproperty
    a_ready_drops_when_off: assert property (p_ready_drops_when_off) else $error("ready stays after turn off");

    property p_reset_held_long;
        $fell(ext_rst_low_oe) |-> oe_cnt_r > RST_MIN_CYC;
    endproperty
    a_reset_held_long: assert property (p_reset_held_long) else $error("reset pin pulse too short");

    property p_reset_drives_low;
        ext_rst_low_oe |-> !ext_rst_low_out && !external_reset_low;
    endproperty
    a_reset_drives_low: assert property (p_reset_drives_low) else $error("reset pin not low while driven");

    property p_ready_low_in_pin_reset;
        low_cnt_r > RST_MIN_CYC + 20'h00005 |-> !tx_ready && stat_word == '0;
    endproperty
    a_ready_low_in_pin_reset: assert property (p_ready_low_in_pin_reset) else $error("ready during reset");

    property p_data_quiet_before_ready;
        ctrl_force && !tx_ready |-> !data;
    endproperty
    a_data_quiet_before_ready: assert property (p_data_quiet_before_ready) else $error("data before ready");

    property p_data_stops_with_force;
        $fell(ctrl_force) |-> !data;
    endproperty
    a_data_stops_with_force: assert property (p_data_stops_with_force) else $error("data after turn off");
endmodule : txrs_properties

// ### tx_reset_and_ready_sequencing_test.sv
// self-checking bench: host and transmitter joined over the link
module tx_reset_and_ready_sequencing_test;
    timeunit 1ns;
    timeprecision 100ps;

    // short counts keep the run brief
    localparam logic [19:0] RST_MIN  = 20'h00014;
    localparam logic [19:0] SETTLE   = 20'h00040;
    localparam logic [19:0] RAMP     = 20'h00010;
    localparam logic [19:0] START    = 20'h00020;
    localparam logic [19:0] OFF_HOLD = 20'h00010;

    logic                 sys_clk_i   = 1'b0;
    logic                 rst_n_i     = 1'b0;
    logic                 auto_mode_i = 1'b0;
    logic                 rst_req_i   = 1'b0;
    logic                 start_i     = 1'b0;
    logic                 auto_i      = 1'b0;
    txrs_pkg::txrs_meth_e method_i    = txrs_pkg::M_TIME;
    logic                 bit_i       = 1'b0;
    logic                 stop_i      = 1'b0;
    logic                 tx_ready_o;
    logic                 tx_on_o;
    logic                 mod_data_o;
    logic                 in_reset_o;
    logic                 busy_o;
    logic                 go_o;
    logic                 done_o;
    int                   error_cnt   = 0;
    int                   n_tests     = 0;

    always #2.5 sys_clk_i = ~sys_clk_i;

    txrs_if txrs_if_inst (.sys_clk_i(sys_clk_i));

    txrs_device #(.RST_MIN_CYC(RST_MIN), .RAMP_CYC(RAMP), .OFF_HOLD_CYC(OFF_HOLD)) txrs_device_inst (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .lnk(txrs_if_inst), .auto_mode_i(auto_mode_i),
        .tx_ready_o(tx_ready_o), .tx_on_o(tx_on_o), .mod_data_o(mod_data_o), .in_reset_o(in_reset_o));

    txrs_host #(.RST_MIN_CYC(RST_MIN), .SETTLE_CYC(SETTLE), .START_CYC(START), .OFF_HOLD_CYC(OFF_HOLD))
    txrs_host_inst (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .lnk(txrs_if_inst), .rst_req_i(rst_req_i),
        .start_i(start_i), .auto_i(auto_i), .method_i(method_i), .bit_i(bit_i), .stop_i(stop_i),
        .busy_o(busy_o), .go_o(go_o), .done_o(done_o));

    txrs_properties #(.RST_MIN_CYC(RST_MIN), .RAMP_CYC(RAMP)) txrs_properties_inst (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ext_rst_low_out(txrs_if_inst.ext_rst_low_out),
        .ext_rst_low_oe(txrs_if_inst.ext_rst_low_oe), .external_reset_low(txrs_if_inst.external_reset_low),
        .ctrl_force(txrs_if_inst.ctrl_force), .data(txrs_if_inst.data), .tx_ready(txrs_if_inst.tx_ready),
        .stat_word(txrs_if_inst.stat_word));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task automatic tick();
        @(posedge sys_clk_i);
        #1;
    endtask : tick

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    // pin reset through the host; the device must enter reset while the pin is held and leave it once released
    task automatic pin_reset();
        int   n;
        logic seen_rst;
        n = 0;
        seen_rst = 1'b0;
        rst_req_i = 1'b1;
        tick();
        rst_req_i = 1'b0;
        while (done_o !== 1'b1 && n < 500) begin
            tick();
            n++;
            if (in_reset_o === 1'b1) seen_rst = 1'b1;
        end
        check("reset_seen", {31'h0, seen_rst}, 32'h1);
        check("reset_len", {31'h0, n > int'(RST_MIN)}, 32'h1);
        check("ready_in_reset", {31'h0, tx_ready_o}, 32'h0);
        repeat (6) tick();
        check("reset_left", {31'h0, in_reset_o}, 32'h0);
    endtask : pin_reset

    // one transfer: turn on, wait by the chosen method, send random bits, stop
    task automatic run_tx(input logic a, input txrs_pkg::txrs_meth_e m);
        int   n;
        int   w;
        logic exp_q[$];
        n = 1;
        w = a ? int'(START) : int'(SETTLE);
        auto_i = a;
        auto_mode_i = a;
        method_i = m;
        start_i = 1'b1;
        tick();
        start_i = 1'b0;
        check("busy_on", {31'h0, busy_o}, 32'h1);
        while (go_o !== 1'b1 && n < 2000) begin
            tick();
            n++;
        end
        check("go", {31'h0, go_o}, 32'h1);
        check("ready_at_go", {31'h0, tx_ready_o}, 32'h1);
        check("flag_at_go", {31'h0, txrs_if_inst.stat_word[1]}, 32'h1);
        if (m == txrs_pkg::M_TIME || (a && m == txrs_pkg::M_POLL))
            check("blind_wait", {31'h0, n >= w - 1}, 32'h1);
        else
            check("early_go", {31'h0, n < w}, 32'h1);
        // the line follows bit_i one edge late; the modulator sees it four edges late
        for (int i = 0; i < 8; i++) begin
            bit_i = 1'($urandom());
            exp_q.push_back(bit_i);
            tick();
            check("data", {31'h0, txrs_if_inst.data}, {31'h0, exp_q[$]});
            if (i >= 3)
                check("mod_data", {31'h0, mod_data_o}, {31'h0, exp_q.pop_front()});
        end
        stop_i = 1'b1;
        tick();
        stop_i = 1'b0;
        n = 0;
        while (done_o !== 1'b1 && n < 500) begin
            tick();
            n++;
        end
        check("done", {31'h0, done_o}, 32'h1);
        check("busy_off", {31'h0, busy_o}, 32'h0);
        check("stop_wait", {31'h0, a ? n >= int'(OFF_HOLD) : n == 0}, 32'h1);
        check("force_off", {30'h0, txrs_if_inst.ctrl_force, txrs_if_inst.data}, 32'h0);
        repeat (6) tick();
        check("off_ready", {30'h0, tx_ready_o, tx_on_o}, 32'h0);
        check("off_flag", {24'h0, txrs_if_inst.stat_word}, 32'h0);
    endtask : run_tx

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        void'($urandom(11));
        repeat (20) @(posedge sys_clk_i);
        #1;
        rst_n_i = 1'b1;
        repeat (6) tick();
        check("boot_reset_left", {31'h0, in_reset_o}, 32'h0);
        check("boot_ready", {31'h0, tx_ready_o}, 32'h0);
        pin_reset();
        for (int a = 0; a < 2; a++) begin
            run_tx(a[0], txrs_pkg::M_TIME);
            run_tx(a[0], txrs_pkg::M_POLL);
            run_tx(a[0], txrs_pkg::M_PIN);
        end
        pin_reset();
        end_of_test();
    end

    // all scenarios together need about five hundred cycles
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        error_cnt++;
        end_of_test();
    end
endmodule : tx_reset_and_ready_sequencing_test
